// [core/hdt_core.sv]
// hdlc d-channel transmitter, receiver and transparent mode with apb registers
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module hdt_core
  import hdt_pkg::*;
#(
  parameter int RX_DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dataClk,
  input wire logic frameSync,
  input wire logic serialRxLine,
  input wire logic stopGo,
  output logic txLine,
  output logic txLineOe,
  output logic hdlcIrq
);
  localparam int RXW = $clog2(RX_DEPTH);

  function automatic logic inSlot(input logic [4:0] p, input logic [2:0] en);
    inSlot = (en[1] && p < POS_B2) || (en[2] && p >= POS_B2 && p < POS_B2_END)
      || (en[0] && p >= POS_D && p < POS_D_END);
  endfunction

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b);
    crcStep = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
  endfunction

  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff, txLine_ff, txLineOe_ff, hdlcIrq_ff;
  logic [7:0] istat_ff, mask_ff, mode_ff, extended_mode_cfg_ff, rxStat_ff;
  logic [2:0] chsel_ff;
  logic loop_ff, tx_block_overflow_ff, itfEff_ff;
  logic [3:0] sync1_ff, sync2_ff;
  logic dclkD_ff, firstPend_ff;
  logic [4:0] bitPos_ff;
  logic [7:0] txMem [64];
  logic [6:0] txWr_ff, txRd_ff, txRel_ff, txCom_ff, txEnd_ff, sent_ff, blkWr_ff, blkSz_ff;
  logic endValid_ff, firstBlk_ff, xprWait_ff, xprEnd_ff;
  hdt_txs_t txState_ff, ldState;
  logic [15:0] txShift_ff, ldShift, txCrc_ff;
  logic [4:0] txCnt_ff, ldCnt;
  logic [2:0] txOnes_ff;
  logic pop, underrun, frameDone;
  logic [7:0] rxMem [RX_DEPTH];
  logic [RXW:0] rxWr_ff, rxRd_ff;
  logic [7:0] rxHist_ff, rxSh_ff;
  logic [2:0] rxCnt_ff, rxOnes_ff;
  logic rxIn_ff, rxGot_ff, rxRun_ff;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign txLine = txLine_ff;
  assign txLineOe = txLineOe_ff;
  assign hdlcIrq = hdlcIrq_ff;

  // apb decode
  wire [7:0] idx = paddr[9:2];
  wire setup = psel && !penable;
  wire acc = ce && psel && penable && pready_ff;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire isFifo = idx <= IDX_FIFO_LAST;
  wire mapped = isFifo || idx == IDX_IRQ || idx == IDX_STAT || idx == IDX_MODE
    || idx == IDX_EXMODE || idx == IDX_RXSTAT || idx == IDX_TEST || idx == IDX_CHSEL;
  wire cmdWr = wr && idx == IDX_STAT;
  wire xresCmd = cmdWr && pwdata[CMD_TRANSMITTER_RESET_CMD];
  wire xtfCmd = cmdWr && pwdata[CMD_XTF];
  wire xmeCmd = cmdWr && pwdata[CMD_XME];
  wire [6:0] blkNew = extended_mode_cfg_ff[EX_XFBS] ? BLK_SMALL : BLK_LARGE;

  // configuration
  wire extMode = mode_ff[7:5] == MODE_EXT;
  wire collMode = !mode_ff[2] && mode_ff[0];
  wire crcOff = extended_mode_cfg_ff[EX_TX_CHECK_DISABLE];

  // serial bus timing on the sampled data clock
  wire dclk = sync2_ff[0];
  wire fs = sync2_ff[1];
  wire stopS = sync2_ff[3];
  wire edgeT = ce && dclk && !dclkD_ff;
  wire [4:0] posNow = fs ? 5'h00 : bitPos_ff + 5'h01;
  wire slotNow = inSlot(posNow, chsel_ff);
  wire bitTick = edgeT && slotNow;
  wire firstSlot = bitTick && (fs || firstPend_ff);

  // transmit fifo state
  wire txLock = istat_ff[IRQ_XMR] || istat_ff[IRQ_XDU];
  wire [6:0] txFree = TXF_SIZE - (txWr_ff - txRel_ff);
  wire endHere = endValid_ff && txRd_ff == txEnd_ff;
  wire avail = txRd_ff != txCom_ff && !endHere;
  wire [7:0] curByte = txMem[txRd_ff[5:0]];
  wire sending = txState_ff inside {TS_OPEN, TS_DATA, TS_CRC, TS_CLOSE};
  wire collide = ce && collMode && stopS && sending;
  wire xmrEv = collide && (extMode || firstBlk_ff);
  wire retryEv = collide && !xmrEv;
  wire startOk = firstSlot && avail && !txLock && !(collMode && stopS);
  wire stuff = !extMode && txState_ff inside {TS_DATA, TS_CRC}
    && txOnes_ff == STUFF_ONES;
  wire txBitNow = stuff ? 1'b0 : ldShift[0];
  wire tickGo = bitTick && !stuff && !xresCmd && !collide;
  wire popEv = tickGo && pop;
  wire undEv = tickGo && underrun;
  wire frameEv = tickGo && frameDone;
  wire txClear = xresCmd || xmrEv || undEv;
  wire fifoWr = wr && isFifo && !txLock && !txClear;
  wire [15:0] fill = (itfEff_ff && !extMode) ? {8'h00, FLAG} : 16'h00ff;
  wire blkDone = popEv && sent_ff + 7'h01 == blkSz_ff;

  // next byte or field to shift out once the current one is done
  always_comb begin
    ldState = txState_ff;
    ldShift = txShift_ff;
    ldCnt = txCnt_ff;
    pop = 1'b0;
    underrun = 1'b0;
    frameDone = 1'b0;
    if (txCnt_ff == 5'h00 || (txState_ff == TS_IDLE && startOk)) begin
      ldCnt = 5'h08;
      case (txState_ff)
        TS_IDLE: begin
          if (startOk && extMode) begin
            ldState = TS_DATA;
            ldShift = {8'h00, curByte};
            pop = 1'b1;
          end else if (startOk) begin
            ldState = TS_OPEN;
            ldShift = {8'h00, FLAG};
          end else begin
            ldShift = fill;
          end
        end
        TS_OPEN, TS_DATA: begin
          if (avail) begin
            ldState = TS_DATA;
            ldShift = {8'h00, curByte};
            pop = 1'b1;
          end else if (endHere && extMode) begin
            ldState = TS_IDLE;
            ldShift = 16'h00ff;
            frameDone = 1'b1;
          end else if (endHere && !crcOff) begin
            ldState = TS_CRC;
            ldShift = ~txCrc_ff;
            ldCnt = 5'h10;
          end else if (endHere) begin
            ldState = TS_CLOSE;
            ldShift = {8'h00, FLAG};
          end else begin
            ldState = TS_ABORT;
            ldShift = 16'h007f;
            ldCnt = ABORT_BITS;
            underrun = 1'b1;
          end
        end
        TS_CRC: begin
          ldState = TS_CLOSE;
          ldShift = {8'h00, FLAG};
        end
        default: begin
          ldState = TS_IDLE;
          ldShift = fill;
          frameDone = txState_ff == TS_CLOSE;
        end
      endcase
    end
  end

  // receive path
  wire rxBit = loop_ff ? txBitNow : sync2_ff[2];
  wire [7:0] histN = {rxBit, rxHist_ff[7:1]};
  wire [7:0] rxByte = {rxBit, rxSh_ff[7:1]};
  wire rxFlag = !extMode && histN == FLAG;
  wire rxSix = !extMode && rxOnes_ff == STUFF_ONES && rxBit;
  wire rxDestuff = !extMode && rxOnes_ff == STUFF_ONES && !rxBit;
  wire rxTake = extMode ? (rxRun_ff || firstSlot) : (rxIn_ff && !rxFlag && !rxSix && !rxDestuff);
  // the first transparent byte restarts the bit count so bytes stay frame aligned
  wire rxAlign = extMode && firstSlot && !rxRun_ff;
  wire rxPush = bitTick && rxTake && rxCnt_ff == 3'h7 && !rxAlign;
  wire rxFull = rxWr_ff - rxRd_ff == (RXW+1)'(RX_DEPTH);
  wire rxEmpty = rxWr_ff == rxRd_ff;
  wire rxPop = rd && isFifo && !rxEmpty;
  wire rfoEv = rxPush && rxFull && !extended_mode_cfg_ff[EX_SRA];
  wire rmeEv = bitTick && rxSix && rxIn_ff && rxGot_ff;
  wire xprEv = xresCmd || (xprWait_ff && txFree >= blkSz_ff)
    || (frameEv && xprEnd_ff);
  wire [7:0] setVec = {rmeEv, 1'b0, rfoEv, xprEv, xmrEv, undEv, 2'b00};
  wire rdIrq = rd && idx == IDX_IRQ;
  wire irqAny = |(istat_ff & ~mask_ff);
  wire [7:0] rdData = isFifo ? rxMem[rxRd_ff[RXW-1:0]]
    : idx == IDX_IRQ ? istat_ff
    : idx == IDX_STAT ? {tx_block_overflow_ff, !txLock && txFree >= blkSz_ff, 6'h00}
    : idx == IDX_MODE ? mode_ff
    : idx == IDX_EXMODE ? extended_mode_cfg_ff
    : idx == IDX_RXSTAT ? rxStat_ff
    : idx == IDX_TEST ? {7'h00, loop_ff}
    : idx == IDX_CHSEL ? {5'h00, chsel_ff} : 8'h00;

  // bus slave and registers; read data is caught in the setup cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      mask_ff <= RST_MASK;
      mode_ff <= RST_MODE;
      extended_mode_cfg_ff <= RST_EXMODE;
      chsel_ff <= RST_CHSEL;
      loop_ff <= 1'b0;
      istat_ff <= RST_IRQ;
      hdlcIrq_ff <= 1'b0;
    end else if (ce) begin
      pready_ff <= setup;
      pslverr_ff <= setup && !mapped;
      if (setup) prdata_ff <= {24'h00_0000, rdData};
      if (wr && idx == IDX_IRQ) mask_ff <= pwdata[7:0];
      if (wr && idx == IDX_MODE) mode_ff <= pwdata[7:0];
      if (wr && idx == IDX_EXMODE) extended_mode_cfg_ff <= pwdata[7:0];
      if (wr && idx == IDX_TEST) loop_ff <= pwdata[0];
      if (wr && idx == IDX_CHSEL) chsel_ff <= pwdata[2:0];
      // only bits seen by the read are cleared; a new event wins
      istat_ff <= (istat_ff & ~(rdIrq ? prdata_ff[7:0] : 8'h00)) | setVec;
      hdlcIrq_ff <= irqAny;
    end
  end

  // input synchronisers and serial frame position
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      dclkD_ff <= 1'b0;
      bitPos_ff <= 5'h00;
      firstPend_ff <= 1'b0;
      txLineOe_ff <= 1'b0;
    end else if (ce) begin
      sync1_ff <= {stopGo, serialRxLine, frameSync, dataClk};
      sync2_ff <= sync1_ff;
      dclkD_ff <= dclk;
      if (edgeT) begin
        bitPos_ff <= posNow;
        firstPend_ff <= (fs || firstPend_ff) && !slotNow;
        txLineOe_ff <= slotNow;
      end
    end
  end

  // transmit fifo pointers, commands and pool ready bookkeeping
  always_ff @(posedge clk_sys) begin
    if (fifoWr) txMem[txWr_ff[5:0]] <= pwdata[7:0];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txWr_ff <= 7'h00;
      txRd_ff <= 7'h00;
      txRel_ff <= 7'h00;
      txCom_ff <= 7'h00;
      txEnd_ff <= 7'h00;
      sent_ff <= 7'h00;
      blkWr_ff <= 7'h00;
      blkSz_ff <= BLK_LARGE;
      endValid_ff <= 1'b0;
      firstBlk_ff <= 1'b0;
      xprWait_ff <= 1'b0;
      xprEnd_ff <= 1'b0;
      tx_block_overflow_ff <= 1'b0;
      itfEff_ff <= 1'b0;
    end else if (ce) begin
      if (txClear) begin
        txWr_ff <= 7'h00;
        txRd_ff <= 7'h00;
        txRel_ff <= 7'h00;
        txCom_ff <= 7'h00;
        endValid_ff <= 1'b0;
        sent_ff <= 7'h00;
        blkWr_ff <= 7'h00;
        firstBlk_ff <= 1'b0;
        xprEnd_ff <= 1'b0;
      end else begin
        if (fifoWr) begin
          txWr_ff <= txWr_ff + 7'h01;
          blkWr_ff <= blkWr_ff + 7'h01;
          if (blkWr_ff >= blkSz_ff) tx_block_overflow_ff <= 1'b1;
        end
        if (xtfCmd || xmeCmd) begin
          txCom_ff <= txWr_ff;
          blkWr_ff <= 7'h00;
        end
        if (xmeCmd) begin
          endValid_ff <= 1'b1;
          txEnd_ff <= txWr_ff;
        end
        if (xtfCmd && xmeCmd) xprEnd_ff <= 1'b1;
        if (retryEv) begin
          txRd_ff <= txRel_ff;
          sent_ff <= 7'h00;
        end else if (frameEv) begin
          txRel_ff <= txRd_ff;
          sent_ff <= 7'h00;
          endValid_ff <= 1'b0;
          firstBlk_ff <= 1'b0;
          xprEnd_ff <= 1'b0;
        end else if (popEv) begin
          txRd_ff <= txRd_ff + 7'h01;
          sent_ff <= blkDone ? 7'h00 : sent_ff + 7'h01;
          if (blkDone) begin
            txRel_ff <= txRd_ff + 7'h01;
            firstBlk_ff <= 1'b1;
          end
        end
      end
      if (xresCmd) tx_block_overflow_ff <= 1'b0;
      if (xtfCmd || xmeCmd || xresCmd) blkSz_ff <= blkNew;
      if ((xtfCmd || xmeCmd) && !(xtfCmd && xmeCmd)) begin
        xprWait_ff <= 1'b1;
      end else if (xresCmd || (xprWait_ff && txFree >= blkSz_ff)) begin
        xprWait_ff <= 1'b0;
      end
      if (xresCmd || frameEv) itfEff_ff <= extended_mode_cfg_ff[EX_ITF];
    end
  end

  // bit serialiser with stuffing and check sequence
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txState_ff <= TS_IDLE;
      txShift_ff <= 16'h0000;
      txCnt_ff <= 5'h00;
      txOnes_ff <= 3'h0;
      txCrc_ff <= CRC_INIT;
      txLine_ff <= 1'b1;
    end else if (ce) begin
      if (xresCmd) begin
        txState_ff <= TS_ABORT;
        txShift_ff <= 16'h007f;
        txCnt_ff <= ABORT_BITS;
        txOnes_ff <= 3'h0;
      end else if (collide) begin
        txState_ff <= TS_IDLE;
        txCnt_ff <= 5'h00;
        txOnes_ff <= 3'h0;
      end else if (bitTick) begin
        txLine_ff <= txBitNow;
        if (!stuff) begin
          txState_ff <= ldState;
          txShift_ff <= ldShift >> 1;
          txCnt_ff <= ldCnt - 5'h01;
        end
        txOnes_ff <= (!stuff && txBitNow && ldState inside {TS_DATA, TS_CRC})
          ? txOnes_ff + 3'h1 : 3'h0;
        if (ldState == TS_OPEN) begin
          txCrc_ff <= CRC_INIT;
        end else if (!stuff && ldState == TS_DATA) begin
          txCrc_ff <= crcStep(txCrc_ff, txBitNow);
        end
      end else if (edgeT) begin
        txLine_ff <= 1'b1;
      end
    end
  end

  // receiver: flag hunt and destuffing, or raw aligned bytes
  always_ff @(posedge clk_sys) begin
    if (rxPush && !rxFull) rxMem[rxWr_ff[RXW-1:0]] <= rxByte;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxWr_ff <= '0;
      rxRd_ff <= '0;
      rxHist_ff <= 8'h00;
      rxSh_ff <= 8'h00;
      rxCnt_ff <= 3'h0;
      rxOnes_ff <= 3'h0;
      rxIn_ff <= 1'b0;
      rxGot_ff <= 1'b0;
      rxRun_ff <= 1'b0;
      rxStat_ff <= RST_RXSTAT;
    end else if (ce) begin
      if (rxPop) rxRd_ff <= rxRd_ff + (RXW+1)'(1);
      if (!extMode) rxRun_ff <= 1'b0;
      if (bitTick) begin
        rxHist_ff <= histN;
        rxOnes_ff <= rxBit ? (rxOnes_ff == 3'h7 ? 3'h7 : rxOnes_ff + 3'h1) : 3'h0;
        if (extMode && firstSlot) rxRun_ff <= 1'b1;
        if (rxFlag) begin
          rxIn_ff <= 1'b1;
          rxCnt_ff <= 3'h0;
          rxGot_ff <= 1'b0;
        end else if (rxSix) begin
          rxIn_ff <= 1'b0;
        end else if (rxTake) begin
          rxSh_ff <= rxByte;
          rxCnt_ff <= rxAlign ? 3'h1 : rxCnt_ff + 3'h1;
        end
        if (rxPush) begin
          rxGot_ff <= 1'b1;
          if (!rxFull) rxWr_ff <= rxWr_ff + (RXW+1)'(1);
          if (extMode) rxStat_ff <= rxByte;
        end
      end
    end
  end

  sequence s_abortGo;
    txState_ff == TS_ABORT && txCnt_ff == ABORT_BITS;
  endsequence

  sequence s_xtfOnly;
    xtfCmd && !xmeCmd && !xresCmd && txFree >= BLK_LARGE;
  endsequence

  property p_lock;
    @(posedge clk_sys) disable iff (rst)
    (wr && isFifo && txLock && !txClear) |=> txWr_ff == $past(txWr_ff);
  endproperty
  a_lock: assert property (p_lock) else $error("write entered locked fifo");

  property p_clear;
    @(posedge clk_sys) disable iff (rst)
    ($rose(istat_ff[IRQ_XDU]) || $rose(istat_ff[IRQ_XMR])) |-> txWr_ff == txRd_ff;
  endproperty
  a_clear: assert property (p_clear) else $error("fifo not cleared on error");

  property p_mask;
    @(posedge clk_sys) disable iff (rst)
    ce |=> hdlcIrq == $past(irqAny);
  endproperty
  a_mask: assert property (p_mask) else $error("irq output ignores mask");

  property p_ovf;
    @(posedge clk_sys) disable iff (rst)
    (fifoWr && blkWr_ff >= blkSz_ff) |=> tx_block_overflow_ff;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow bit not set");

  property p_abort;
    @(posedge clk_sys) disable iff (rst)
    undEv |=> txState_ff == TS_ABORT && txLine_ff && istat_ff[IRQ_XDU];
  endproperty
  a_abort: assert property (p_abort) else $error("underrun did not abort");

  property p_itf;
    @(posedge clk_sys) disable iff (rst)
    (!frameEv && !xresCmd) |=> $stable(itfEff_ff);
  endproperty
  a_itf: assert property (p_itf) else $error("fill changed mid frame");

  property p_crc;
    @(posedge clk_sys) disable iff (rst)
    (ce && txState_ff == TS_DATA && crcOff) |=> txState_ff != TS_CRC;
  endproperty
  a_crc: assert property (p_crc) else $error("crc sent while disabled");

  property p_xpr;
    @(posedge clk_sys) disable iff (rst)
    s_xtfOnly |-> ##[1:2] istat_ff[IRQ_XPR];
  endproperty
  a_xpr: assert property (p_xpr) else $error("no pool ready after command");

  property p_transmitter_reset_cmd;
    @(posedge clk_sys) disable iff (rst)
    xresCmd |=> s_abortGo ##0 istat_ff[IRQ_XPR] && txWr_ff == 7'h00;
  endproperty
  a_transmitter_reset_cmd: assert property (p_transmitter_reset_cmd) else $error("reset did not abort");
endmodule

// [pkg/hdt_pkg.sv]
// shared constants and types for the hdlc transmit / transparent block
package hdt_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FIFO_LAST = 8'h1f;
  localparam logic [7:0] IDX_IRQ = 8'h20;
  localparam logic [7:0] IDX_STAT = 8'h21;
  localparam logic [7:0] IDX_MODE = 8'h22;
  localparam logic [7:0] IDX_EXMODE = 8'h23;
  localparam logic [7:0] IDX_RXSTAT = 8'h28;
  localparam logic [7:0] IDX_TEST = 8'h29;
  localparam logic [7:0] IDX_CHSEL = 8'h2a;
  // reset values
  localparam logic [7:0] RST_IRQ = 8'h10;
  localparam logic [7:0] RST_MASK = 8'hff;
  localparam logic [7:0] RST_MODE = 8'hc0;
  localparam logic [7:0] RST_EXMODE = 8'h00;
  localparam logic [7:0] RST_RXSTAT = 8'h0f;
  localparam logic [2:0] RST_CHSEL = 3'h1;
  // bit positions
  localparam int IRQ_RME = 7;
  localparam int IRQ_RFO = 5;
  localparam int IRQ_XPR = 4;
  localparam int IRQ_XMR = 3;
  localparam int IRQ_XDU = 2;
  localparam int CMD_XTF = 3;
  localparam int CMD_XME = 1;
  localparam int CMD_TRANSMITTER_RESET_CMD = 0;
  localparam int EX_XFBS = 7;
  localparam int EX_SRA = 4;
  localparam int EX_TX_CHECK_DISABLE = 3;
  localparam int EX_ITF = 0;
  // mode and framing
  localparam logic [2:0] MODE_EXT = 3'h4;
  localparam logic [7:0] FLAG = 8'h7e;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [4:0] ABORT_BITS = 5'h07;
  localparam logic [2:0] STUFF_ONES = 3'h5;
  localparam logic [6:0] BLK_SMALL = 7'h10;
  localparam logic [6:0] BLK_LARGE = 7'h20;
  localparam logic [6:0] TXF_SIZE = 7'h40;
  // bit positions of the channels inside a 32-bit serial frame
  localparam logic [4:0] POS_B2 = 5'h08;
  localparam logic [4:0] POS_B2_END = 5'h10;
  localparam logic [4:0] POS_D = 5'h18;
  localparam logic [4:0] POS_D_END = 5'h1a;
  typedef enum logic [2:0] {TS_IDLE, TS_OPEN, TS_DATA, TS_CRC, TS_CLOSE, TS_ABORT} hdt_txs_t;
endpackage

// [verif/dchannel_hdlc_tx_error_transparent_bench.sv]
// self-checking bench: apb register tasks and transmit / transparent scenarios
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module dchannel_hdlc_tx_error_transparent_bench;
  import hdt_pkg::*;
  logic clk_sys, rst, psel, penable, pwrite, stopReq, rdErr;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, dataClk, frameSync, serialRxLine, stopGo, txLine, txLineOe, hdlcIrq;
  logic [7:0] rdv;
  logic [15:0] crc;
  logic [39:0] rxExp;
  int flagCnt, bad_count, cmp_count;
  logic [7:0] ridx [7] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h28, 8'h29, 8'h2a};
  logic [7:0] rexp [7] = '{8'h10, 8'h40, 8'hc0, 8'h00, 8'h0f, 8'h00, 8'h01};
  hdt_core DUT (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dataClk(dataClk), .frameSync(frameSync), .serialRxLine(serialRxLine),
    .stopGo(stopGo), .txLine(txLine), .txLineOe(txLineOe), .hdlcIrq(hdlcIrq));
  hdt_bus_model bus (.dataClk(dataClk), .frameSync(frameSync), .serialRxLine(serialRxLine),
    .stopGo(stopGo), .txLine(txLine), .txLineOe(txLineOe), .stopReq(stopReq), .flagCnt(flagCnt));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    // hold the request until pready is seen high at a rising edge
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdv = prdata[7:0];
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic wait_irq();
    repeat (9000) begin
      @(negedge clk_sys);
      if (hdlcIrq === 1'b1)
        break;
    end
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys);
    bad_count++;
    wrap_up();
  end
  initial begin
    bad_count = 0;
    cmp_count = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h00000000;
    stopReq = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ridx[i], 8'h00);
      `CHK("reset value", rexp[i], rdv)
    end
    apb(1'b0, 8'h30, 8'h00);
    `CHK("unmapped error", 1'b1, rdErr)
    // block overflow, then transmitter reset
    wreg(8'h2a, 8'h06);
    for (int i = 0; i < 33; i++)
      wreg(8'h00, 8'(i));
    apb(1'b0, 8'h21, 8'h00);
    `CHK("overflow bit", 1'b1, rdv[7])
    wreg(8'h21, 8'h01);
    wreg(8'h20, 8'hef);
    wait_irq();
    apb(1'b0, 8'h20, 8'h00);
    `CHK("pool ready after reset", 8'h10, rdv & 8'h10)
    repeat (3) @(negedge clk_sys);
    `CHK("irq after clear", 1'b0, hdlcIrq)
    // looped hdlc frame with check sequence and flag fill
    wreg(8'h29, 8'h01);
    wreg(8'h23, 8'h01);
    for (int i = 0; i < 3; i++)
      wreg(8'h00, 8'h30 + 8'(i));
    wreg(8'h21, 8'h0a);
    apb(1'b0, 8'h20, 8'h00);
    `CHK("no early pool ready", 8'h00, rdv & 8'h10)
    wreg(8'h20, 8'hef);
    wait_irq();
    apb(1'b0, 8'h20, 8'h00);
    `CHK("looped frame end", 8'h90, rdv & 8'h90)
    `CHK("flags on wire", 1'b1, flagCnt > 0)
    // looped bytes: frame body then the inverted check sequence, low byte first
    rxExp = {16'h0000, 24'h323130};
    crc = CRC_INIT;
    for (int i = 0; i < 24; i++)
      crc = (crc >> 1) ^ ((crc[0] ^ rxExp[i]) ? CRC_POLY : 16'h0000);
    rxExp[39:24] = ~crc;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'h00, 8'h00);
      `CHK("looped byte", rxExp[8*i +: 8], rdv)
    end
    for (int i = 3; i < 5; i++) begin
      apb(1'b0, 8'h00, 8'h00);
      `CHK("check sequence byte", rxExp[8*i +: 8], rdv)
    end
    // extended transparent mode through the loop
    wreg(8'h22, 8'h80);
    wreg(8'h23, 8'h00);
    wreg(8'h2a, 8'h02);
    wreg(8'h20, 8'hff);
    repeat (40) apb(1'b0, 8'h00, 8'h00);
    wreg(8'h00, 8'ha5);
    wreg(8'h00, 8'h3c);
    wreg(8'h21, 8'h0a);
    wreg(8'h20, 8'hef);
    wait_irq();
    apb(1'b0, 8'h20, 8'h00);
    `CHK("transparent end", 8'h10, rdv & 8'h10)
    repeat (40) begin
      apb(1'b0, 8'h00, 8'h00);
      if (rdv === 8'ha5)
        break;
    end
    `CHK("raw first byte", 8'ha5, rdv)
    apb(1'b0, 8'h00, 8'h00);
    `CHK("raw second byte", 8'h3c, rdv)
    apb(1'b0, 8'h28, 8'h00);
    `CHK("byte mirror", 8'h3c, rdv)
    repeat (1400) @(posedge clk_sys);
    apb(1'b0, 8'h00, 8'h00);
    `CHK("idle ones", 8'hff, rdv)
    // stop during transmission in collision mode
    wreg(8'h22, 8'h81);
    wreg(8'h20, 8'hf7);
    wreg(8'h00, 8'h11);
    wreg(8'h00, 8'h22);
    wreg(8'h21, 8'h08);
    repeat (700) @(posedge clk_sys);
    stopReq <= 1'b1;
    wait_irq();
    apb(1'b0, 8'h20, 8'h00);
    `CHK("message repeat", 8'h08, rdv & 8'h08)
    stopReq <= 1'b0;
    // host never refills: underrun
    wreg(8'h22, 8'h80);
    wreg(8'h00, 8'h55);
    wreg(8'h21, 8'h08);
    wreg(8'h20, 8'hfb);
    wait_irq();
    apb(1'b0, 8'h20, 8'h00);
    `CHK("underrun", 8'h04, rdv & 8'h04)
    wrap_up();
  end
endmodule

// [verif/hdt_bus_model.sv]
// serial time-division bus partner: bit clock, frame sync, receive data, transmit capture
`timescale 1ns/100ps
module hdt_bus_model (
  output logic dataClk,
  output logic frameSync,
  output logic serialRxLine,
  output logic stopGo,
  input wire logic txLine,
  input wire logic txLineOe,
  input wire logic stopReq,
  output int flagCnt
);
  logic [4:0] bitCnt;
  logic [7:0] shiftIn;
  initial begin
    dataClk = 1'b0;
    bitCnt = 5'h1f;
    frameSync = 1'b0;
    serialRxLine = 1'b0;
    stopGo = 1'b0;
    shiftIn = 8'h00;
    flagCnt = 0;
    forever #80 dataClk = ~dataClk;
  end
  // the bus clock runs free; sync marks the rise of bit 0
  always @(negedge dataClk) begin
    bitCnt <= bitCnt + 5'h01;
    frameSync <= (bitCnt == 5'h1f);
    serialRxLine <= ~serialRxLine;
    stopGo <= stopReq;
  end
  // transmit bits arrive lsb first; count flag patterns in enabled slots
  always @(negedge dataClk) begin
    if (txLineOe) begin
      shiftIn = {txLine, shiftIn[7:1]};
      if (shiftIn == 8'h7e)
        flagCnt++;
    end
  end
endmodule
